// ==== chg_pkg.sv ====
// Constants, types and carriers shared by the charger control logic
package chg_pkg;
  // ==========================================================
  // Register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_FLOAT = 8'h02;
  localparam logic [7:0] REG_CURR = 8'h04;
  localparam logic [7:0] REG_SPEC = 8'h05;
  localparam logic [7:0] REG_SAFE = 8'h06;
  localparam int CTRL_RESTART_BIT = 7;
  localparam int CFG_TE_BIT = 3;
  localparam int CFG_CE_N_BIT = 2;
  localparam int SPEC_FLOOR_BIT = 4;
  // Reset values
  localparam logic [7:0] DEF_CFG = 8'h00;
  localparam logic [7:0] DEF_FLOAT = 8'h08;
  localparam logic [7:0] DEF_CURR = 8'h00;
  localparam logic [7:0] DEF_SPEC = 8'h00;
  localparam logic [7:0] DEF_SAFE = 8'h40;
  // Status and fault codes
  localparam logic [1:0] STAT_READY = 2'h0;
  localparam logic [1:0] STAT_CHG = 2'h1;
  localparam logic [1:0] STAT_DONE = 2'h2;
  localparam logic [1:0] STAT_FAULT = 2'h3;
  localparam logic [2:0] FAULT_NONE = 3'h0;
  localparam logic [2:0] FAULT_TIMER = 3'h6;
  // ==========================================================
  // Timing: one tick per millisecond
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_MS;
  localparam int UNATT_MIN = 15;
  localparam int UNATT_TICKS = UNATT_MIN * 60_000 / TICK_MS;
  localparam int SUP_S = 32;
  localparam int SUP_TICKS = SUP_S * 1000 / TICK_MS;
  localparam int DONE_MS = 500;
  localparam int DONE_TICKS = DONE_MS / TICK_MS;
  localparam int VALID_MS = 30;
  localparam int VALID_TICKS = VALID_MS / TICK_MS;
  // ==========================================================
  // Decode scales (sense in 0.1 mV, voltages in mV)
  localparam logic [9:0] ICHG_BASE = 10'h176;
  localparam logic [9:0] ICHG_STEP = 10'h044;
  localparam logic [8:0] TERM_CURRENT_CODE_STEP_STD = 9'h022;
  localparam logic [8:0] TERM_CURRENT_CODE_STEP_SPC = 9'h021;
  localparam logic [12:0] VFLOOR_BASE = 13'h1075;
  localparam logic [12:0] VFLOOR_STEP = 13'h0050;
  localparam logic [12:0] VFLOAT_BASE = 13'h0DAC;
  localparam logic [12:0] VFLOAT_STEP = 13'h0014;
  localparam logic [5:0] VFLOAT_TOP_CODE = 6'h2F;
  localparam logic [12:0] VFLOAT_MAX = 13'h1158;
  localparam logic [5:0] VCEIL_BASE_CODE = 6'h23;
  localparam logic [5:0] FLOAT_CODE_MAX = 6'h32;
  localparam logic [15:0] ILIM_100 = 16'h0064;
  localparam logic [15:0] ILIM_500 = 16'h01F4;
  localparam logic [15:0] ILIM_800 = 16'h0320;
  localparam logic [15:0] ILIM_NONE = 16'hFFFF;
  // ==========================================================
  // Types and carriers
  typedef enum logic [2:0] {S_IDLE, S_VALID, S_CHARGE, S_READY, S_DONE} chg_st_t;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_REG, L_DATA, L_READ} chg_lnk_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } chg_wr_t;
  typedef struct packed {
    logic supplyAboveMin;
    logic supplyOverVolt;
    logic batBelowWeak;
    logic batBelowShort;
    logic chargeBelowTerm;
    logic floorLoopLimit;
    logic hostModePin;
  } chg_ana_t;
  typedef struct packed {
    logic chargerOn;
    logic loadApply;
    logic statPulse;
    logic [1:0] stat;
    logic [2:0] fault;
    logic [15:0] inputLimitMa;
    logic [9:0] chargeSense;
    logic [8:0] termSense;
    logic [12:0] floatMv;
    logic [12:0] floorMv;
    logic [9:0] ceilSense;
    logic floorLoopActive;
  } chg_out_t;
endpackage

// ==== chg_control_timers.sv ====
// Charger control: serial register port, safety timers, supply validation, limits
`timescale 1ns/1ps
`default_nettype none
module chg_control_timers import chg_pkg::*; #(
  parameter bit AUTO_CHARGE = 1'b1,
  parameter bit SPECIAL_CHARGER = 1'b1,
  parameter logic [6:0] DEV_ADDR = 7'h35, // arbitrary value
  parameter logic [15:0] TICK_LEN = 16'(TICK_CYCLES - 1),
  parameter logic [19:0] UNATT_LEN = 20'(UNATT_TICKS),
  parameter logic [19:0] SUP_LEN = 20'(SUP_TICKS),
  parameter logic [19:0] DONE_LEN = 20'(DONE_TICKS),
  parameter logic [19:0] VALID_LEN = 20'(VALID_TICKS)
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link: clock that runs the port logic, and the two lines
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Analog comparator levels and host-mode pin
  input wire chg_ana_t anaIn,
  // Charger commands and status
  output chg_out_t chgOut
);
  // ==========================================================
  // Parameter checks
  if (UNATT_LEN == 20'h0 || SUP_LEN == 20'h0 || DONE_LEN == 20'h0 || VALID_LEN == 20'h0) begin : gChk
    $error("timer lengths must be nonzero");
  end

  // ==========================================================
  // Link domain
  logic [1:0] lRstSy;
  logic [1:0] sclSy;
  logic [1:0] sdaSy;
  logic sclD;
  logic sdaD;
  chg_lnk_t lSt;
  logic [3:0] bitCnt;
  logic [7:0] shReg;
  logic [7:0] regPtr;
  logic [7:0] rdByte;
  logic wrTog;
  logic rdReq;
  chg_wr_t wrHold;
  logic [7:0] rdAddr;
  logic [2:0] rdAckSy;
  logic sdaOe_r;
  logic rdAck;
  logic [7:0] rdData_r;
  wire logic lRst = lRstSy[1];
  wire logic sclS = sclSy[1];
  wire logic sdaS = sdaSy[1];
  wire logic startC = sclS & sclD & sdaD & ~sdaS;
  wire logic stopC = sclS & sclD & ~sdaD & sdaS;
  wire logic sclRise = sclS & ~sclD;
  wire logic sclFall = ~sclS & sclD;

  // Reset and line synchronisers; first stage feeds only the second
  always_ff @(posedge linkClk) begin
    lRstSy <= {lRstSy[0], rst};
    sclSy <= {sclSy[0], sclIn};
    sdaSy <= {sdaSy[0], sdaIn};
    sclD <= sclS;
    sdaD <= sdaS;
  end

  // Read answer toggles back from the system side
  always_ff @(posedge linkClk) begin
    if (lRst) begin
      rdAckSy <= 3'h0;
      rdByte <= 8'h00;
    end else begin
      rdAckSy <= {rdAckSy[1:0], rdAck};
      if (rdAckSy[2] ^ rdAckSy[1]) begin
        rdByte <= rdData_r; // Stable since the toggle was raised
      end
    end
  end

  // Byte engine: address, register pointer, data, reads
  always_ff @(posedge linkClk) begin
    if (lRst) begin
      lSt <= L_IDLE;
      bitCnt <= 4'h0;
      shReg <= 8'h00;
      regPtr <= 8'h00;
      wrTog <= 1'b0;
      rdReq <= 1'b0;
      wrHold <= '0;
      rdAddr <= 8'h00;
      sdaOe_r <= 1'b0;
    end else if (startC) begin
      lSt <= L_ADDR;
      bitCnt <= 4'h0;
      sdaOe_r <= 1'b0;
    end else if (stopC) begin
      lSt <= L_IDLE;
      sdaOe_r <= 1'b0;
    end else if (sclRise && lSt != L_IDLE) begin
      if (bitCnt == 4'h8) begin
        bitCnt <= 4'h0;
        case (lSt)
          L_ADDR: begin
            if (shReg[7:1] != DEV_ADDR) begin
              lSt <= L_IDLE;
            end else if (shReg[0]) begin
              lSt <= L_READ;
            end else begin
              lSt <= L_REG;
            end
          end
          L_REG: begin
            regPtr <= shReg;
            rdAddr <= shReg;
            rdReq <= ~rdReq;
            lSt <= L_DATA;
          end
          L_DATA: begin
            wrHold <= '{addr: regPtr, data: shReg};
            wrTog <= ~wrTog;
            regPtr <= regPtr + 8'h01;
          end
          L_READ: begin
            if (sdaS) begin
              lSt <= L_IDLE; // Master refused more data
            end else begin
              regPtr <= regPtr + 8'h01;
              rdAddr <= regPtr + 8'h01;
              rdReq <= ~rdReq;
            end
          end
          default: lSt <= L_IDLE;
        endcase
      end else begin
        shReg <= {shReg[6:0], sdaS};
        bitCnt <= bitCnt + 4'h1;
      end
    end else if (sclFall && lSt != L_IDLE) begin
      if (bitCnt == 4'h8) begin
        sdaOe_r <= (lSt != L_READ) && (lSt != L_ADDR || shReg[7:1] == DEV_ADDR);
      end else if (lSt == L_READ) begin
        sdaOe_r <= ~rdByte[3'(4'h7 - bitCnt)]; // Open drain: drive low for a zero
      end else begin
        sdaOe_r <= 1'b0;
      end
    end
  end

  // Line drive is always low when enabled
  always_ff @(posedge linkClk) begin
    sdaOut <= 1'b0;
    sdaOe <= sdaOe_r;
  end

  // ==========================================================
  // System domain: crossings and inputs
  logic [2:0] wrTogSy;
  logic [2:0] rdReqSy;
  chg_ana_t anaSy0;
  chg_ana_t ana;
  logic supplyRiseD;
  logic shortD;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrTogSy <= 3'h0;
      rdReqSy <= 3'h0;
      anaSy0 <= '0;
      ana <= '0;
      supplyRiseD <= 1'b0;
      shortD <= 1'b1;
    end else begin
      wrTogSy <= {wrTogSy[1:0], wrTog};
      rdReqSy <= {rdReqSy[1:0], rdReq};
      anaSy0 <= anaIn;
      ana <= anaSy0;
      supplyRiseD <= ana.supplyAboveMin;
      shortD <= ana.batBelowShort;
    end
  end
  wire logic hostWr = wrTogSy[2] ^ wrTogSy[1];
  wire logic rdPulse = rdReqSy[2] ^ rdReqSy[1];
  wire logic supplyRise = ana.supplyAboveMin & ~supplyRiseD;
  wire logic supplyOk = ana.supplyAboveMin & ~ana.supplyOverVolt;
  wire logic shortRise = ~ana.batBelowShort & shortD;

  // ==========================================================
  // Time base and timers
  logic [15:0] tickCnt;
  logic tick;
  logic unattRun;
  logic [19:0] unattCnt;
  logic supRun;
  logic [19:0] supCnt;
  chg_st_t st;
  logic [19:0] stCnt;
  wire logic restartWr = hostWr && wrHold.addr == REG_CTRL && wrHold.data[CTRL_RESTART_BIT];
  wire logic unattExp = unattRun && tick && unattCnt == UNATT_LEN - 20'h1;
  wire logic supExp = supRun && tick && supCnt == SUP_LEN - 20'h1;
  wire logic chargeBegin = st == S_VALID && tick && stCnt == VALID_LEN - 20'h1 && supplyOk;

  // One free-running tick feeds every timer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tickCnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= tickCnt == TICK_LEN;
      tickCnt <= (tickCnt == TICK_LEN) ? 16'h0000 : tickCnt + 16'h0001;
    end
  end

  // Unattended timer; host writes take it over
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unattRun <= 1'b0;
      unattCnt <= 20'h0;
    end else if (hostWr) begin
      unattRun <= 1'b0;
      unattCnt <= 20'h0;
    end else if (supExp || (chargeBegin && !supRun)) begin
      unattRun <= 1'b1;
      unattCnt <= 20'h0;
    end else if (unattExp) begin
      unattRun <= 1'b0;
      unattCnt <= 20'h0;
    end else if (unattRun && tick) begin
      unattCnt <= unattCnt + 20'h1;
    end
  end

  // Supervision timer; any host write restarts it and keeps host control alive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supRun <= 1'b0;
      supCnt <= 20'h0;
    end else if (hostWr) begin
      supRun <= 1'b1;
      supCnt <= 20'h0;
    end else if (supExp) begin
      supRun <= 1'b0;
      supCnt <= 20'h0;
    end else if (supRun && tick) begin
      supCnt <= supCnt + 20'h1;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] cfgR;
  logic [7:0] floatR;
  logic [7:0] currR;
  logic [7:0] specR;
  logic [7:0] safeR;
  logic safeLock;
  logic [2:0] faultR;
  logic statPulseR;
  wire logic [5:0] vCeilSum = VCEIL_BASE_CODE + {2'b00, safeR[3:0]};
  wire logic [5:0] maxFloat = (vCeilSum > FLOAT_CODE_MAX) ? FLOAT_CODE_MAX : vCeilSum;
  wire logic bootWeak = supplyRise && AUTO_CHARGE && ana.batBelowWeak;
  wire logic reloadDef = supExp || bootWeak;
  wire logic cfgWr = hostWr && wrHold.addr == REG_CFG;
  wire logic floorActive = SPECIAL_CHARGER && ana.floorLoopLimit && st == S_CHARGE;

  // Host-programmed settings; float and charge current clamped to the safety ceilings
  always_ff @(posedge sys_clk) begin
    if (rst || reloadDef) begin
      cfgR <= DEF_CFG;
      floatR <= DEF_FLOAT;
      currR <= DEF_CURR;
      specR <= DEF_SPEC;
    end else begin
      if (cfgWr) begin
        cfgR <= wrHold.data;
      end
      if (unattExp) begin
        cfgR[CFG_CE_N_BIT] <= 1'b1;
      end
      if (hostWr && wrHold.addr == REG_FLOAT) begin
        floatR <= {(wrHold.data[7:2] > maxFloat) ? maxFloat : wrHold.data[7:2], 2'b00};
      end
      if (hostWr && wrHold.addr == REG_CURR) begin
        currR <= {1'b0, (wrHold.data[6:4] > safeR[6:4]) ? safeR[6:4] : wrHold.data[6:4],
                  1'b0, wrHold.data[2:0]};
      end
      if (hostWr && wrHold.addr == REG_SPEC) begin
        specR <= {5'h00, wrHold.data[2:0]};
      end
    end
  end

  // Safety ceilings: writable until another register is written; a battery short reopens them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      safeR <= DEF_SAFE;
      safeLock <= 1'b0;
    end else if (ana.batBelowShort || shortRise) begin
      safeLock <= 1'b0;
      if (shortRise) begin
        safeR <= DEF_SAFE;
      end
    end else if (hostWr) begin
      if (wrHold.addr != REG_SAFE) begin
        safeLock <= 1'b1;
      end else if (!safeLock) begin
        safeR <= {1'b0, wrHold.data[6:0]};
      end
    end
  end

  // Fault field: hardware setting wins over a host clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      faultR <= FAULT_NONE;
      statPulseR <= 1'b0;
    end else begin
      statPulseR <= supExp;
      if (unattExp || supExp) begin
        faultR <= FAULT_TIMER;
      end else if (hostWr && wrHold.addr == REG_CTRL) begin
        faultR <= FAULT_NONE;
      end
    end
  end

  // Read snapshot for the link
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_r <= 8'h00;
      rdAck <= 1'b0;
    end else if (rdPulse) begin
      rdAck <= ~rdAck;
      case (rdAddr)
        REG_CTRL: rdData_r <= {2'b00, chgOut.stat, 1'b0, faultR};
        REG_CFG: rdData_r <= cfgR;
        REG_FLOAT: rdData_r <= floatR;
        REG_CURR: rdData_r <= currR;
        REG_SPEC: rdData_r <= specR | (8'(floorActive) << SPEC_FLOOR_BIT);
        REG_SAFE: rdData_r <= safeR;
        default: rdData_r <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Charge sequence
  wire logic hostStart = cfgWr && !wrHold.data[CFG_CE_N_BIT];
  wire logic porStart = supplyRise && AUTO_CHARGE && (ana.batBelowWeak || !cfgR[CFG_CE_N_BIT]);
  wire logic termHit = cfgR[CFG_TE_BIT] && ana.chargeBelowTerm && supRun;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= S_IDLE;
      stCnt <= 20'h0;
    end else if (unattExp) begin
      st <= S_IDLE;
      stCnt <= 20'h0;
    end else begin
      case (st)
        S_IDLE, S_DONE: begin
          stCnt <= 20'h0;
          if (porStart || hostStart) begin
            st <= S_VALID;
          end else if (st == S_DONE && !ana.supplyAboveMin) begin
            st <= S_IDLE;
          end
        end
        S_VALID: begin
          if (!supplyOk) begin
            stCnt <= 20'h0;
          end else if (chargeBegin) begin
            st <= S_CHARGE;
            stCnt <= 20'h0;
          end else if (tick) begin
            stCnt <= stCnt + 20'h1;
          end
        end
        S_CHARGE: begin
          stCnt <= 20'h0;
          if (!supplyOk) begin
            st <= S_VALID;
          end else if (termHit) begin
            st <= S_READY;
          end
        end
        S_READY: begin
          if (tick && stCnt == DONE_LEN - 20'h1) begin
            st <= supplyOk ? S_DONE : S_IDLE;
            stCnt <= 20'h0;
          end else if (tick) begin
            stCnt <= stCnt + 20'h1;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Registered outputs with decoded settings
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chgOut <= '0;
    end else begin
      chgOut.chargerOn <= st == S_CHARGE;
      chgOut.loadApply <= st == S_VALID;
      chgOut.statPulse <= statPulseR;
      chgOut.fault <= faultR;
      case (st)
        S_CHARGE, S_VALID: chgOut.stat <= STAT_CHG;
        S_DONE: chgOut.stat <= STAT_DONE;
        S_READY: chgOut.stat <= STAT_READY;
        default: chgOut.stat <= (faultR != FAULT_NONE) ? STAT_FAULT : STAT_READY;
      endcase
      if (AUTO_CHARGE && unattRun) begin
        chgOut.inputLimitMa <= ana.hostModePin ? ILIM_500 : ILIM_100;
      end else begin
        case (cfgR[7:6])
          2'h0: chgOut.inputLimitMa <= ILIM_100;
          2'h1: chgOut.inputLimitMa <= ILIM_500;
          2'h2: chgOut.inputLimitMa <= ILIM_800;
          default: chgOut.inputLimitMa <= ILIM_NONE;
        endcase
      end
      chgOut.chargeSense <= ICHG_BASE + ICHG_STEP * {7'h00, currR[6:4]};
      chgOut.ceilSense <= ICHG_BASE + ICHG_STEP * {7'h00, safeR[6:4]};
      chgOut.termSense <= (SPECIAL_CHARGER ? TERM_CURRENT_CODE_STEP_SPC : TERM_CURRENT_CODE_STEP_STD) * ({6'h00, currR[2:0]} + 9'h001);
      chgOut.floorMv <= VFLOOR_BASE + VFLOOR_STEP * {10'h000, specR[2:0]};
      chgOut.floatMv <= (floatR[7:2] > VFLOAT_TOP_CODE) ? VFLOAT_MAX :
                        VFLOAT_BASE + VFLOAT_STEP * {7'h00, floatR[7:2]};
      chgOut.floorLoopActive <= floorActive;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_unatt_fault: assert property (unattExp && !reloadDef |=> faultR == FAULT_TIMER && cfgR[CFG_CE_N_BIT] && st == S_IDLE)
    else $error("unattended expiry did not stop charging");
  a_sup_reload: assert property (supExp && !hostWr |=> floatR == DEF_FLOAT && unattRun && !supRun)
    else $error("supervision expiry did not reload");
  a_stat_pulse: assert property (supExp |-> ##2 chgOut.statPulse && chgOut.fault == FAULT_TIMER)
    else $error("status pulse missing");
  a_host_wr: assert property (hostWr |=> !unattRun && supRun && supCnt == 20'h0)
    else $error("host write did not swap timers");
  a_restart_bit: assert property (restartWr ##1 (!hostWr && !supExp)[*2] |-> supCnt <= 20'h1)
    else $error("restart bit did not restart timer");
  a_valid_gate: assert property (st == S_VALID && !supplyOk && !unattExp |=> st == S_VALID && stCnt == 20'h0)
    else $error("charging began on invalid supply");
  a_term_gate: assert property (st == S_CHARGE && !cfgR[CFG_TE_BIT] && !unattExp |=> st != S_READY)
    else $error("termination while disabled");
  a_ready_done: assert property (st == S_READY && tick && stCnt == DONE_LEN - 20'h1 && supplyOk && !unattExp
                                 |=> st == S_DONE ##1 chgOut.stat == STAT_DONE)
    else $error("ready did not become done");
  a_float_clamp: assert property (hostWr && wrHold.addr == REG_FLOAT && !reloadDef |=> floatR[7:2] <= $past(maxFloat))
    else $error("float code above ceiling");
  a_safe_lock: assert property (safeLock && !ana.batBelowShort && !shortRise && hostWr |=> $stable(safeR))
    else $error("locked safety register changed");
  a_ilim_pin: assert property (AUTO_CHARGE && unattRun |=> chgOut.inputLimitMa == ($past(ana.hostModePin) ? ILIM_500 : ILIM_100))
    else $error("input limit not from host-mode pin");
  c_done: cover property (st == S_READY ##1 st == S_DONE);
  c_unatt: cover property (unattExp);
  c_sup: cover property (supExp ##1 unattRun);
  c_lock: cover property (safeLock && hostWr && wrHold.addr == REG_SAFE);
endmodule
`default_nettype wire

// ==== chg_host_model.sv ====
// Two-wire host master model for the charger register port
`timescale 1ns/1ps
`default_nettype none
module chg_host_model #(
  parameter logic [6:0] ADDR = 7'h35 // arbitrary value
) (
  // Resolved data line level
  input wire logic sdaLine,
  // Open-drain pulls, high pulls the line low
  output logic sclLow,
  output logic sdaLow
);
  // ==========================================================
  // Bit level
  // Slow half period gives the port's two-flop sync ample margin
  localparam time HALF = 200ns;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // Data moves a quarter after clock fall, never at an edge
  task automatic bitIo(input logic b, output logic r);
    #(HALF/4) sdaLow = !b;
    #HALF sclLow = 1'b0;
    #(HALF/2) r = sdaLine;
    #(HALF/2) sclLow = 1'b1;
  endtask
  task automatic frameStart;
    #(HALF/4) sdaLow = 1'b0;
    #HALF sclLow = 1'b0;
    #HALF sdaLow = 1'b1;
    #HALF sclLow = 1'b1;
  endtask
  task automatic frameStop;
    #(HALF/4) sdaLow = 1'b1;
    #HALF sclLow = 1'b0;
    #HALF sdaLow = 1'b0;
    #HALF;
  endtask
  // ==========================================================
  // Bytes and transfers, MSB first
  task automatic sendByte(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ok &= (r === 1'b0);
  endtask
  // Each byte is refused so the read ends after it
  task automatic getByte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(1'b1, r);
  endtask
  // Host writes start and steer charging
  task automatic wr(input logic [7:0] a, input logic [7:0] d, inout logic ok);
    frameStart();
    sendByte({ADDR, 1'b0}, ok);
    sendByte(a, ok);
    sendByte(d, ok);
    frameStop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, inout logic ok);
    frameStart();
    sendByte({ADDR, 1'b0}, ok);
    sendByte(a, ok);
    frameStart();
    sendByte({ADDR, 1'b1}, ok);
    getByte(d);
    frameStop();
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the charger control and timer block
`timescale 1ns/1ps
`default_nettype none
module testbench import chg_pkg::*;;
  logic sys_clk, rst, linkClk, sclLow, sdaLow, sdaOut, sdaOe, ok;
  chg_ana_t ana;
  chg_out_t chgOut;
  logic [7:0] rdData;
  int n_errors, samples_checked, k;
  wire logic sdaLine = !(sdaLow || (sdaOe && !sdaOut));
  // ==========================================================
  // Design with short timers, four cycles a tick
  chg_control_timers #(.TICK_LEN(16'h0003), .UNATT_LEN(20'h00028), .SUP_LEN(20'h00190),
    .DONE_LEN(20'h00005), .VALID_LEN(20'h00003)) chg_control_timers_i (.sys_clk(sys_clk), .rst(rst),
    .linkClk(linkClk), .sclIn(!sclLow), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .anaIn(ana), .chgOut(chgOut));
  chg_host_model chg_host_model_i (.sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end
  // Link clock free-running, phase unrelated
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = !linkClk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300us;
    n_errors++;
    wrap_up();
  end
  // ==========================================================
  // Scenarios
  initial begin
    rst = 1'b1;
    ana = '0;
    ok = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(2);
    chk("limit", ILIM_100, chgOut.inputLimitMa);
    chk("float", 16'h0DD4, 16'(chgOut.floatMv));
    chk("floor", 16'h1075, 16'(chgOut.floorMv));
    ana.batBelowWeak = 1'b1;
    ana.hostModePin = 1'b1;
    ana.supplyAboveMin = 1'b1;
    for (k = 0; k < 10 && chgOut.loadApply !== 1'b1; k++) tick(1);
    chk("load", 16'h0001, 16'(chgOut.loadApply));
    chk("early", 16'h0000, 16'(chgOut.chargerOn));
    for (k = 0; k < 40 && chgOut.chargerOn !== 1'b1; k++) tick(1);
    chk("on", 16'h0001, 16'(chgOut.chargerOn));
    chk("limit", ILIM_500, chgOut.inputLimitMa);
    chk("ichg", 16'h0176, 16'(chgOut.chargeSense));
    ana.chargeBelowTerm = 1'b1;
    tick(20);
    chk("keep", 16'h0001, 16'(chgOut.chargerOn));
    for (k = 0; k < 250 && chgOut.chargerOn !== 1'b0; k++) tick(1);
    tick(2);
    chk("fault", 16'(FAULT_TIMER), 16'(chgOut.fault));
    ana.chargeBelowTerm = 1'b0;
    chg_host_model_i.wr(REG_CURR, 8'h72, ok);
    chg_host_model_i.wr(REG_SAFE, 8'h70, ok);
    chg_host_model_i.rd(REG_SAFE, rdData, ok);
    chk("safe", 16'(DEF_SAFE), 16'(rdData));
    chg_host_model_i.wr(REG_CTRL, 8'h80, ok);
    chg_host_model_i.rd(REG_CURR, rdData, ok);
    chk("curr", 16'h0042, 16'(rdData));
    chk("ichg", 16'h0286, 16'(chgOut.chargeSense));
    chk("ceil", 16'h0286, 16'(chgOut.ceilSense));
    chk("term_current_code", 16'h0063, 16'(chgOut.termSense));
    chg_host_model_i.wr(REG_FLOAT, 8'hFC, ok);
    chk("vclamp", 16'h1068, 16'(chgOut.floatMv));
    chg_host_model_i.wr(REG_CFG, 8'h88, ok);
    for (k = 0; k < 100 && chgOut.chargerOn !== 1'b1; k++) tick(1);
    chk("limit", ILIM_800, chgOut.inputLimitMa);
    ana.floorLoopLimit = 1'b1;
    tick(4);
    chk("floorloop", 16'h0001, 16'(chgOut.floorLoopActive));
    ana.floorLoopLimit = 1'b0;
    ana.supplyOverVolt = 1'b1;
    tick(8);
    chk("reval", 16'h0001, 16'(chgOut.loadApply));
    ana.supplyOverVolt = 1'b0;
    for (k = 0; k < 40 && chgOut.chargerOn !== 1'b1; k++) tick(1);
    chk("on", 16'h0001, 16'(chgOut.chargerOn));
    ana.chargeBelowTerm = 1'b1;
    for (k = 0; k < 20 && chgOut.chargerOn !== 1'b0; k++) tick(1);
    chk("ready", 16'(STAT_READY), 16'(chgOut.stat));
    for (k = 0; k < 60 && chgOut.stat !== STAT_DONE; k++) tick(1);
    chk("done", 16'(STAT_DONE), 16'(chgOut.stat));
    ana.chargeBelowTerm = 1'b0;
    for (k = 0; k < 2000 && chgOut.statPulse !== 1'b1; k++) tick(1);
    chk("pulse", 16'h0001, 16'(chgOut.statPulse));
    tick(2);
    chk("fault", 16'(FAULT_TIMER), 16'(chgOut.fault));
    chk("ichg", 16'h0176, 16'(chgOut.chargeSense));
    chk("ack", 16'h0001, 16'(ok));
    wrap_up();
  end
endmodule
`default_nettype wire
